// *** src/dsr_sequencer.sv ***
// display controller core: external reset sequencing, host access, flash divider
// assumes host pins and the display clock are asynchronous to sys_clk
// Function
// R1: external reset clears character, flash and control memory and timing counters
// R2: sequence ends three display clock edges after reset input rises
// R3: host must not access the display while the sequence runs
// R4: every character location is filled with the space code
// R5: flash bits and control word are written to zero
// R6: glyph memory and glyph pointer keep their contents
// R7: all displays on one clock must be reset together
// R8: reset input low with chip select high is a reset; other lines ignored
// R9: host must not drive reset, chip select and write low together
// R10: host should reset the display after power up
// R11: flash and blink phase divides display clock by 28672
// R12: normal access resumes by itself once the sequence completes
`timescale 1ns/1ps
module dsr_sequencer (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic disp_clk,
	input wire logic rst_pin_n,
	input wire logic ce_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic flash_memory_select_n,
	input wire logic [dsr_pkg::ADDR_W-1:0] addr,
	input wire logic [dsr_pkg::DATA_W-1:0] data_in,
	output logic [dsr_pkg::DATA_W-1:0] rd_data_reg,
	output logic [dsr_pkg::DATA_W-1:0] ctrl_reg,
	output logic [dsr_pkg::DATA_W-1:0] flash_reg,
	output logic [dsr_pkg::ADDR_W-1:0] glyph_ptr_reg,
	output logic flash_phase_reg,
	output logic busy_reg
);
	import dsr_pkg::*;
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [SYNC_W-1:0] sync3_reg;
	always_ff @(posedge sys_clk) begin
		sync1_reg <= {disp_clk, rst_pin_n, ce_n, wr_n, rd_n, flash_memory_select_n, addr, data_in};
		sync2_reg <= sync1_reg;
		sync3_reg <= sync2_reg;
	end
	wire disp_s = sync2_reg[18];
	wire rst_s_n = sync2_reg[17];
	wire ce_s_n = sync2_reg[16];
	wire wr_s_n = sync2_reg[15];
	wire rd_s_n = sync2_reg[14];
	wire fl_s_n = sync2_reg[13];
	wire [ADDR_W-1:0] addr_s = sync2_reg[12:8];
	wire [DATA_W-1:0] data_s = sync2_reg[7:0];
	wire disp_edge = disp_s & ~sync3_reg[18];
	wire wr_fall = ~wr_s_n & sync3_reg[15];
	////////////////////////////////////////////////////////////////////////////
	// decode
	dsr_state_t state_reg;
	dsr_state_t state_next;
	logic [1:0] edge_cnt_reg;
	logic [2:0] clr_idx_reg;
	logic clr_done_reg;
	logic [14:0] div_cnt_reg;
	logic [DATA_W-1:0] mem_rdata;
	wire idle = (state_reg == ST_IDLE);
	wire reset_req = ~rst_s_n & ce_s_n; // [R8]
	wire bus_wr = idle & ~reset_req & ~ce_s_n & wr_fall; // [R12]
	wire wr_flash = bus_wr & ~fl_s_n;
	wire wr_char = bus_wr & fl_s_n & addr_s[ADDR_CHAR_BIT];
	wire wr_ctrl = bus_wr & fl_s_n & ~addr_s[ADDR_CHAR_BIT] & addr_s[ADDR_CTRL_BIT];
	wire wr_glyph = bus_wr & fl_s_n & ~addr_s[ADDR_CHAR_BIT] & ~addr_s[ADDR_CTRL_BIT];
	wire clearing = ~idle & ~clr_done_reg;
	wire mem_we = clearing | wr_char;
	wire [CHAR_AW-1:0] mem_waddr = clearing ? clr_idx_reg : addr_s[CHAR_AW-1:0];
	wire [DATA_W-1:0] mem_wdata = clearing ? SPACE_CODE : data_s; // [R4]
	wire seq_end = (state_reg == ST_SEQ) & (edge_cnt_reg == SEQ_LAST_EDGE) & disp_edge
		& clr_done_reg & ~reset_req; // [R2] [R8]
	wire div_wrap = idle & disp_edge & (div_cnt_reg == FLASH_HALF_LAST); // [R11]
	wire bus_rd = idle & ~ce_s_n & ~rd_s_n;
	wire [DATA_W-1:0] rd_sel = ~fl_s_n ? {7'h00, flash_reg[addr_s[CHAR_AW-1:0]]}
		: addr_s[ADDR_CHAR_BIT] ? mem_rdata
		: addr_s[ADDR_CTRL_BIT] ? ctrl_reg : {3'h0, glyph_ptr_reg};
	dsr_char_mem u_char_mem (
		.sys_clk(sys_clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(addr_s[CHAR_AW-1:0]),
		.rdata(mem_rdata)
	);
	////////////////////////////////////////////////////////////////////////////
	// state machine
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (reset_req) begin
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (rst_s_n) begin
					state_next = ST_SEQ;
				end
			end
			ST_SEQ: begin
				if (reset_req) begin
					state_next = ST_HOLD; // [R8]
				end else if (seq_end) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_SEQ;
			end
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= ST_SEQ;
			busy_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			busy_reg <= (state_next != ST_IDLE); // [R12]
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst || idle) begin
			edge_cnt_reg <= 2'h0;
		end else if (state_reg == ST_HOLD) begin
			edge_cnt_reg <= 2'h0;
		end else if (disp_edge && edge_cnt_reg != SEQ_LAST_EDGE) begin
			edge_cnt_reg <= edge_cnt_reg + 2'h1; // [R2]
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst || idle) begin
			clr_idx_reg <= 3'h0;
			clr_done_reg <= 1'b0;
		end else if (clearing) begin
			clr_idx_reg <= clr_idx_reg + 3'h1; // [R4]
			clr_done_reg <= (clr_idx_reg == CHAR_LAST);
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// registers reached by the host
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !idle) begin
			ctrl_reg <= CTRL_RESET; // [R1] [R5]
			flash_reg <= FLASH_RESET; // [R5]
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= data_s;
			end
			if (wr_flash) begin
				flash_reg[addr_s[CHAR_AW-1:0]] <= data_s[0];
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			glyph_ptr_reg <= GLYPH_PTR_RESET;
		end else if (wr_glyph) begin
			glyph_ptr_reg <= data_s[ADDR_W-1:0]; // [R6]
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_data_reg <= 8'h00;
		end else if (bus_rd) begin
			rd_data_reg <= rd_sel;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// flash and blink divider
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !idle) begin
			div_cnt_reg <= 15'h0000; // [R1]
			flash_phase_reg <= 1'b0;
		end else if (div_wrap) begin
			div_cnt_reg <= 15'h0000; // [R11]
			flash_phase_reg <= ~flash_phase_reg;
		end else if (disp_edge) begin
			div_cnt_reg <= div_cnt_reg + 15'h0001;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// checks
	hold_clears_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
		(state_reg == ST_HOLD) |=> (div_cnt_reg == 15'h0000) && !flash_phase_reg)
		else $error("counters not cleared in reset");
	seq_length_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
		$rose(state_reg == ST_SEQ) ##0 (disp_edge == 1'b0) [*3] |-> (state_reg != ST_IDLE))
		else $error("sequence ended early");
	blank_fill_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R4]
		clearing |-> mem_we && (mem_wdata == SPACE_CODE) && (mem_waddr == clr_idx_reg))
		else $error("clear did not write space");
	zero_flash_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R5]
		!idle |=> (flash_reg == 8'h00) && (ctrl_reg == 8'h00))
		else $error("flash or control not zero");
	glyph_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
		!idle ##1 !idle |-> $stable(glyph_ptr_reg))
		else $error("glyph pointer changed in reset");
	reset_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
		(idle && reset_req) |=> (state_reg == ST_HOLD) && busy_reg)
		else $error("reset request not taken");
	divider_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R11]
		div_wrap |=> (flash_phase_reg != $past(flash_phase_reg)) && (div_cnt_reg == 15'h0000))
		else $error("flash phase did not toggle");
	resume_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
		seq_end |=> !busy_reg && idle)
		else $error("access not resumed after sequence");
	rerun_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
		(state_reg == ST_SEQ && reset_req) |=> (state_reg == ST_HOLD) && busy_reg)
		else $error("reset request in sequence not taken");
	fill_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R4]
		(clearing && clr_idx_reg == CHAR_LAST) |=> clr_done_reg)
		else $error("fill did not end after last location");
	busy_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
		busy_reg == !idle)
		else $error("busy flag does not follow state");
endmodule : dsr_sequencer

// *** src/dsr_pkg.sv ***
// constants for the display reset sequencer
// assumes one system clock at 40 mhz; display pins arrive asynchronously
package dsr_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	localparam int CHAR_AW = 3;
	localparam int SYNC_W = 19;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] FLASH_RESET = 8'h00;
	localparam logic [4:0] GLYPH_PTR_RESET = 5'h00;
	localparam logic [1:0] SEQ_LAST_EDGE = 2'h2;
	localparam logic [2:0] CHAR_LAST = 3'h7;
	localparam int FLASH_DIV = 28672;
	localparam logic [14:0] FLASH_HALF_LAST = 15'(FLASH_DIV / 2 - 1);
	localparam int ADDR_CHAR_BIT = 4;
	localparam int ADDR_CTRL_BIT = 3;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HOLD = 3'b010,
		ST_SEQ = 3'b100
	} dsr_state_t;
endpackage : dsr_pkg

// *** src/dsr_char_mem.sv ***
// eight-entry character memory with registered read data
// assumes writes and reads come from logic on sys_clk
`timescale 1ns/1ps
module dsr_char_mem (
	input wire logic sys_clk,
	input wire logic we,
	input wire logic [dsr_pkg::CHAR_AW-1:0] waddr,
	input wire logic [dsr_pkg::DATA_W-1:0] wdata,
	input wire logic [dsr_pkg::CHAR_AW-1:0] raddr,
	output logic [dsr_pkg::DATA_W-1:0] rdata
);
	import dsr_pkg::*;
	logic [DATA_W-1:0] mem [0:(1<<CHAR_AW)-1];
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : dsr_char_mem

// *** testbench/dsr_host_model.sv ***
// host model: drives the display pins, changing them at the falling clock edge
// assumes sys_clk from the bench and busy from the device
`timescale 1ns/1ps
module dsr_host_model (
	input wire logic sys_clk,
	input wire logic busy,
	output logic rst_pin_n,
	output logic ce_n,
	output logic wr_n,
	output logic rd_n,
	output logic flash_memory_select_n,
	output logic [dsr_pkg::ADDR_W-1:0] addr,
	output logic [dsr_pkg::DATA_W-1:0] data_in
);
	import dsr_pkg::*;
	initial begin
		{rst_pin_n, ce_n, wr_n, rd_n, flash_memory_select_n} = 5'h1f;
		addr = 5'h00;
		data_in = 8'h00;
	end
	task automatic access(input logic w, input logic f, input logic [4:0] a, input logic [7:0] d);
		while (busy !== 1'b0) @(negedge sys_clk);
		{ce_n, flash_memory_select_n, addr, data_in} = {1'b0, f, a, d};
		if (w) wr_n = 1'b0;
		else rd_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		{wr_n, rd_n} = 2'h3;
		@(negedge sys_clk);
		{ce_n, flash_memory_select_n, addr, data_in} = {2'h3, ~a, ~d};
		repeat (3) @(negedge sys_clk);
	endtask : access
	task automatic reset_pulse(input int len, input logic [15:0] noise);
		@(negedge sys_clk);
		{rst_pin_n, ce_n} = 2'h1;
		{wr_n, rd_n, flash_memory_select_n, addr, data_in} = noise;
		repeat (len) @(negedge sys_clk);
		{rst_pin_n, wr_n, rd_n, flash_memory_select_n} = 4'hf;
	endtask : reset_pulse
endmodule : dsr_host_model

// *** testbench/test_display_reset_sequencer.sv ***
// testbench for the display reset sequencer: host model drives, watcher compares
// assumes the design package and the host model are compiled first
`timescale 1ns/1ps
module test_display_reset_sequencer;
	import dsr_pkg::*;
	typedef struct {int unsigned sel; logic [7:0] val;} dsr_exp_t;
	logic sys_clk, sys_rst, disp_clk, rst_pin_n, ce_n, wr_n, rd_n, fl_n, busy_reg, phase;
	logic [4:0] addr, glyph_ptr_reg, ptr_v;
	logic [7:0] data_in, rd_data_reg, ctrl_reg, flash_reg, ctrl_v, ch;
	int fail_count = 0;
	int tests_run = 0;
	int seed = 68055;
	int n;
	// display clock period is four system cycles
	localparam int DIV_WAIT = FLASH_DIV / 2 * 4;
	dsr_exp_t exp_q[$];
	dsr_exp_t e;
	dsr_sequencer i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .disp_clk(disp_clk),
		.rst_pin_n(rst_pin_n), .ce_n(ce_n), .wr_n(wr_n), .rd_n(rd_n),
		.flash_memory_select_n(fl_n), .addr(addr), .data_in(data_in),
		.rd_data_reg(rd_data_reg), .ctrl_reg(ctrl_reg), .flash_reg(flash_reg),
		.glyph_ptr_reg(glyph_ptr_reg), .flash_phase_reg(phase), .busy_reg(busy_reg));
	dsr_host_model i_host (.sys_clk(sys_clk), .busy(busy_reg), .rst_pin_n(rst_pin_n),
		.ce_n(ce_n), .wr_n(wr_n), .rd_n(rd_n), .flash_memory_select_n(fl_n),
		.addr(addr), .data_in(data_in));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		disp_clk = 1'b0;
		forever #50 disp_clk = ~disp_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string name, input logic [7:0] x, input logic [7:0] g);
		tests_run++;
		if (g !== x) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, x, g);
		end
	endtask : cmp
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy_reg !== 1'b0 && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		cmp("busy after reset", 8'h00, {7'h00, busy_reg});
	endtask : wait_idle
	always @(posedge rd_n) begin
		while (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			case (e.sel)
				0: cmp("read data", e.val, rd_data_reg);
				1: cmp("control word", e.val, ctrl_reg);
				2: cmp("flash bits", e.val, flash_reg);
				default: cmp("glyph pointer", e.val, {3'h0, glyph_ptr_reg});
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		repeat (4) @(negedge sys_clk);
		sys_rst = 1'b0;
		i_host.reset_pulse(12, 16'hffff);
		wait_idle();
		for (int i = 0; i < 8; i++) begin
			ch = 8'($random(seed));
			i_host.access(1'b1, 1'b1, {2'h2, i[2:0]}, ch);
			i_host.access(1'b1, 1'b0, {2'h0, i[2:0]}, 8'($random(seed)));
		end
		ctrl_v = 8'($random(seed));
		ptr_v = 5'($random(seed));
		i_host.access(1'b1, 1'b1, 5'h08, ctrl_v);
		i_host.access(1'b1, 1'b1, 5'h00, {3'h0, ptr_v});
		exp_q.push_back('{1, ctrl_v});
		exp_q.push_back('{0, ch});
		i_host.access(1'b0, 1'b1, 5'h17, 8'h00);
		i_host.reset_pulse(20, 16'($random(seed)));
		cmp("busy in reset", 8'h01, {7'h00, busy_reg});
		wait_idle();
		exp_q.push_back('{1, CTRL_RESET});
		exp_q.push_back('{2, FLASH_RESET});
		exp_q.push_back('{3, {3'h0, ptr_v}});
		for (int i = 0; i < 8; i++) begin
			exp_q.push_back('{0, SPACE_CODE});
			i_host.access(1'b0, 1'b1, {2'h2, i[2:0]}, 8'h00);
		end
		ch = 8'($random(seed));
		i_host.access(1'b1, 1'b1, 5'h13, ch);
		exp_q.push_back('{0, ch});
		i_host.access(1'b0, 1'b1, 5'h13, 8'h00);
		i_host.reset_pulse(6, 16'hffff);
		wait_idle();
		cmp("flash phase after reset", 8'h00, {7'h00, phase});
		n = 0;
		while (phase !== 1'b1 && n < 60000) begin
			@(negedge sys_clk);
			n++;
		end
		cmp("flash half period", 8'h01, {7'h00, n > DIV_WAIT - 4 && n <= DIV_WAIT});
		test_done();
	end
	initial begin
		repeat (70000) @(posedge sys_clk);
		fail_count++;
		test_done();
	end
endmodule : test_display_reset_sequencer
